// ==== pkg/sbi_pkg.sv ====
package sbi_pkg;
    localparam int CMD_W = 12;
    localparam int AD_W = 64;
    localparam int ECC_W = 8;
    localparam int STATE_W = 3;
    localparam int RESP_W = 5;
    // reset value of active-low outputs except interface reset and enables: deasserted
    localparam logic INACTIVE_N = 1'b1;
    // release pulse length in interface cycles
    localparam int REL_CYCLES = 1;
    // agent issue kinds
    typedef enum logic [1:0] {
        SBI_ISSUE_CMD,
        SBI_ISSUE_RESP,
        SBI_ISSUE_NONE
    } sbi_issue_e;
endpackage : sbi_pkg

// ==== verilog/sbi_check.sv ====
`timescale 1ns/100ps
// odd parity checker for one receive path
module sbi_check #(
    parameter int W = 12
) (
    input wire logic clk_in,        // interface clock
    input wire logic rst_n_in,      // async reset, active low
    input wire logic [W-1:0] data_in, // sampled bus
    input wire logic par_in,        // received parity bit
    input wire logic valid_in,      // sample qualifier
    output logic err_out            // registered parity error
);
    logic err_q;
    wire odd_ok = ^{data_in, par_in};

    // odd parity: data plus parity has odd ones count
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            err_q <= 1'b0;
        end else begin
            err_q <= valid_in && !odd_ok;
        end
    end
    assign err_out = err_q;
endmodule : sbi_check

// ==== verilog/sbi_agent.sv ====
`timescale 1ns/100ps
// Operation
// - agent grants mastership to processor by driving grant low.
// - master pulses release low one cycle, then gives up mastership next cycle.
// - agent asserts read ready only while read and upgrade requests acceptable.
// - agent asserts write ready only while write and eliminate requests acceptable.
// - commands travel on shared 12-bit bus driven by master.
// - command driver also drives odd parity over command bits.
// - 64-bit address/data with 8-bit ecc, made by driver, checked by receiver; agent sends ecc_in as given and passes received ecc to rx_ecc_out unchecked.
// - master drives valid low exactly in cycles with meaningful bus content.
// - agent reports completion responses on a 5-bit response bus.
// - agent drives odd parity over the response bus.
// - agent pulses response valid one cycle per completion response.
// - agent drives interface reset low to reset the processor.
// - agent drives nonmaskable interrupt input low to signal it.
// - agent asserts globally performed only when all requests are performed.
// - agent may use emulation cycle to qualify interface cycles.
module sbi_agent #(
    parameter int AD_W = sbi_pkg::AD_W,
    parameter int ECC_W = sbi_pkg::ECC_W
) (
    input wire logic clk_in,                              // interface clock
    input wire logic rst_n_in,                            // async reset, active low
    // user side
    input wire logic sys_reset_req_in,                    // hold processor in reset
    input wire logic nmi_req_in,                          // raise nmi level
    input wire logic read_ok_in,                          // can take reads
    input wire logic write_ok_in,                         // can take writes
    input wire logic grant_en_in,                         // allow granting
    input wire logic all_performed_in,                    // outstanding all performed
    input wire logic emu_mode_in,                         // emulation cycle qualifying
    input wire logic emu_cycle_in,                        // virtual cycle strobe
    input wire logic cmd_req_in,                          // issue one command word
    input wire logic [sbi_pkg::CMD_W-1:0] cmd_in,         // command to send
    input wire logic [AD_W-1:0] ad_in,                    // address/data to send
    input wire logic [ECC_W-1:0] ecc_in,                  // check bits to send
    input wire logic resp_req_in,                         // issue completion response
    input wire logic [sbi_pkg::RESP_W-1:0] resp_in,       // response code
    output logic cmd_ack_out,                             // command word sent pulse
    output logic resp_ack_out,                            // response sent pulse
    output logic rx_valid_out,                            // processor word received
    output logic [sbi_pkg::CMD_W-1:0] rx_cmd_out,         // received command
    output logic [AD_W-1:0] rx_ad_out,                    // received address/data
    output logic [ECC_W-1:0] rx_ecc_out,                  // received check bits
    output logic rx_cmd_perr_out,                         // command parity error
    output logic state_valid_out,                         // state response received
    output logic [sbi_pkg::STATE_W-1:0] state_out,        // received state
    output logic state_perr_out,                          // state parity error
    output logic cor_err_out,                             // processor corrected error
    output logic unc_err_out,                             // processor tag error
    output logic proc_master_out,                         // processor holds bus
    // pins toward the processor
    input wire logic bus_request_n_in,                    // processor request
    output logic bus_grant_n_out,                         // grant
    input wire logic mastership_release_n_in,             // release pin sampled
    output logic mastership_release_n_out,                // release drive value
    output logic mastership_release_oe_n_out,             // release enable, low drives
    output logic read_accept_ready_n_out,                 // read ready
    output logic write_accept_ready_n_out,                // write ready
    input wire logic [sbi_pkg::CMD_W-1:0] command_bus_in, // command pin in
    output logic [sbi_pkg::CMD_W-1:0] command_bus_out,    // command pin out
    output logic command_bus_oe_n_out,                    // command enable
    input wire logic command_parity_in,                   // parity in
    output logic command_parity_out,                      // parity out
    input wire logic [AD_W-1:0] addr_data_bus_in,         // ad pin in
    output logic [AD_W-1:0] addr_data_bus_out,            // ad pin out
    output logic addr_data_bus_oe_n_out,                  // ad/ecc enable
    input wire logic [ECC_W-1:0] addr_data_ecc_in,        // ecc in
    output logic [ECC_W-1:0] addr_data_ecc_out,           // ecc out
    input wire logic bus_valid_n_in,                      // valid pin in
    output logic bus_valid_n_out,                         // valid pin out
    output logic bus_valid_oe_n_out,                      // valid enable
    input wire logic [sbi_pkg::STATE_W-1:0] coherency_state_bus_in, // state bus
    input wire logic coherency_state_parity_in,           // state parity
    input wire logic coherency_state_valid_n_in,          // state valid
    output logic [sbi_pkg::RESP_W-1:0] completion_response_bus_out, // response bus
    output logic completion_response_parity_out,         // response parity
    output logic completion_response_valid_n_out,         // response valid
    output logic interface_reset_n_out,                   // processor reset
    output logic nonmaskable_irq_n_out,                   // nmi
    input wire logic corrected_error_pulse_n_in,          // corrected error
    input wire logic uncorrectable_error_pulse_n_in,      // tag error
    output logic globally_performed_n_out,                // globally performed
    output logic emulation_cycle_n_out                    // emulation cycle
);
    typedef enum logic [1:0] {
        SBI_AGENT_MASTER,
        SBI_PROC_MASTER,
        SBI_AGENT_RELEASE
    } sbi_arb_e;

    function automatic logic odd_par12(input logic [sbi_pkg::CMD_W-1:0] v);
        odd_par12 = ~^v;
    endfunction : odd_par12

    function automatic logic odd_par5(input logic [sbi_pkg::RESP_W-1:0] v);
        odd_par5 = ~^v;
    endfunction : odd_par5

    sbi_arb_e arb_q, arb_d;
    logic grant_n_q, rel_n_q, rel_oe_n_q, rrdy_n_q, wrdy_n_q, proc_master_q;
    logic [sbi_pkg::CMD_W-1:0] cmd_q, rx_cmd_q;
    logic cpar_q, cmd_oe_n_q, val_n_q, val_oe_n_q, cmd_ack_q;
    logic [AD_W-1:0] ad_q, rx_ad_q;
    logic [ECC_W-1:0] ecc_q, rx_ecc_q;
    logic [sbi_pkg::RESP_W-1:0] resp_q;
    logic rpar_q, rval_n_q, resp_ack_q, rx_valid_q, sval_q, cor_q, unc_q;
    logic [sbi_pkg::STATE_W-1:0] state_q;
    logic sreset_n_q, nmi_n_q, gperf_n_q, cyc_n_q;

    // one cycle of agent activity allowed per virtual cycle in emulation
    wire cyc_ok = !emu_mode_in || emu_cycle_in;
    wire agent_owns = (arb_q == SBI_AGENT_MASTER);
    wire send_cmd = agent_owns && cmd_req_in && cyc_ok;
    // grant when processor requests and agent idle
    wire give_bus = agent_owns && grant_en_in && !bus_request_n_in && !send_cmd && cyc_ok;
    // processor release seen, bus returns next cycle
    wire proc_rel = (arb_q == SBI_PROC_MASTER) && !mastership_release_n_in;
    wire send_resp = resp_req_in && cyc_ok;
    wire proc_word = (arb_q == SBI_PROC_MASTER) && !bus_valid_n_in;

    // arbitration next state
    always_comb begin
        arb_d = arb_q;
        unique case (arb_q)
            SBI_AGENT_MASTER: if (give_bus) arb_d = SBI_AGENT_RELEASE;
            SBI_AGENT_RELEASE: arb_d = SBI_PROC_MASTER;
            SBI_PROC_MASTER: if (proc_rel) arb_d = SBI_AGENT_MASTER;
        endcase
    end

    // all pins registered on rising edge
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            arb_q <= SBI_AGENT_MASTER;
            grant_n_q <= sbi_pkg::INACTIVE_N;
            rel_n_q <= sbi_pkg::INACTIVE_N;
            rel_oe_n_q <= 1'b0;
            proc_master_q <= 1'b0;
        end else begin
            arb_q <= arb_d;
            // grant only after the release cycle, held while processor owns
            grant_n_q <= (arb_d != SBI_PROC_MASTER);
            proc_master_q <= (arb_d == SBI_PROC_MASTER);
            // one-cycle release pulse, then driver let go
            rel_n_q <= !give_bus;
            rel_oe_n_q <= (arb_d == SBI_PROC_MASTER);
        end
    end

    // agent-side command/ad drive
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cmd_q <= '0;
            cpar_q <= 1'b1;
            ad_q <= '0;
            ecc_q <= '0;
            cmd_oe_n_q <= 1'b0;
            val_n_q <= sbi_pkg::INACTIVE_N;
            val_oe_n_q <= 1'b0;
            cmd_ack_q <= 1'b0;
        end else begin
            // agent drives buses only while master
            cmd_oe_n_q <= (arb_d == SBI_PROC_MASTER);
            val_oe_n_q <= (arb_d == SBI_PROC_MASTER);
            // valid low only with a real word
            val_n_q <= !send_cmd;
            cmd_ack_q <= send_cmd;
            if (send_cmd) begin
                cmd_q <= cmd_in;
                cpar_q <= odd_par12(cmd_in);
                ad_q <= ad_in;
                ecc_q <= ecc_in;
            end
        end
    end

    // flow control and misc levels
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rrdy_n_q <= sbi_pkg::INACTIVE_N;
            wrdy_n_q <= sbi_pkg::INACTIVE_N;
            sreset_n_q <= 1'b0;
            nmi_n_q <= sbi_pkg::INACTIVE_N;
            gperf_n_q <= sbi_pkg::INACTIVE_N;
            cyc_n_q <= sbi_pkg::INACTIVE_N;
        end else begin
            rrdy_n_q <= !read_ok_in;
            wrdy_n_q <= !write_ok_in;
            sreset_n_q <= !sys_reset_req_in;
            nmi_n_q <= !nmi_req_in;
            gperf_n_q <= !all_performed_in;
            cyc_n_q <= !(emu_mode_in && emu_cycle_in);
        end
    end

    // completion responses
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            resp_q <= '0;
            rpar_q <= 1'b1;
            rval_n_q <= sbi_pkg::INACTIVE_N;
            resp_ack_q <= 1'b0;
        end else begin
            rval_n_q <= !send_resp;
            resp_ack_q <= send_resp;
            if (send_resp) begin
                resp_q <= resp_in;
                rpar_q <= odd_par5(resp_in);
            end
        end
    end

    // receive side: processor words, state, error pulses
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_valid_q <= 1'b0;
            rx_cmd_q <= '0;
            rx_ad_q <= '0;
            rx_ecc_q <= '0;
            sval_q <= 1'b0;
            state_q <= '0;
            cor_q <= 1'b0;
            unc_q <= 1'b0;
        end else begin
            rx_valid_q <= proc_word;
            if (proc_word) begin
                rx_cmd_q <= command_bus_in;
                rx_ad_q <= addr_data_bus_in;
                rx_ecc_q <= addr_data_ecc_in;
            end
            sval_q <= !coherency_state_valid_n_in;
            if (!coherency_state_valid_n_in) state_q <= coherency_state_bus_in;
            cor_q <= !corrected_error_pulse_n_in;
            unc_q <= !uncorrectable_error_pulse_n_in;
        end
    end

    sbi_check #(.W(sbi_pkg::CMD_W)) u_cmd_chk (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .data_in(command_bus_in),
        .par_in(command_parity_in),
        .valid_in(proc_word),
        .err_out(rx_cmd_perr_out)
    );

    sbi_check #(.W(sbi_pkg::STATE_W)) u_state_chk (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .data_in(coherency_state_bus_in),
        .par_in(coherency_state_parity_in),
        .valid_in(!coherency_state_valid_n_in),
        .err_out(state_perr_out)
    );

    // pin and user outputs, all registered
    assign bus_grant_n_out = grant_n_q;
    assign mastership_release_n_out = rel_n_q;
    assign mastership_release_oe_n_out = rel_oe_n_q;
    assign read_accept_ready_n_out = rrdy_n_q;
    assign write_accept_ready_n_out = wrdy_n_q;
    assign command_bus_out = cmd_q;
    assign command_parity_out = cpar_q;
    assign command_bus_oe_n_out = cmd_oe_n_q;
    assign addr_data_bus_out = ad_q;
    assign addr_data_ecc_out = ecc_q;
    assign addr_data_bus_oe_n_out = cmd_oe_n_q;
    assign bus_valid_n_out = val_n_q;
    assign bus_valid_oe_n_out = val_oe_n_q;
    assign completion_response_bus_out = resp_q;
    assign completion_response_parity_out = rpar_q;
    assign completion_response_valid_n_out = rval_n_q;
    assign interface_reset_n_out = sreset_n_q;
    assign nonmaskable_irq_n_out = nmi_n_q;
    assign globally_performed_n_out = gperf_n_q;
    assign emulation_cycle_n_out = cyc_n_q;
    assign cmd_ack_out = cmd_ack_q;
    assign resp_ack_out = resp_ack_q;
    assign rx_valid_out = rx_valid_q;
    assign rx_cmd_out = rx_cmd_q;
    assign rx_ad_out = rx_ad_q;
    assign rx_ecc_out = rx_ecc_q;
    assign state_valid_out = sval_q;
    assign state_out = state_q;
    assign cor_err_out = cor_q;
    assign unc_err_out = unc_q;
    assign proc_master_out = proc_master_q;

    // release pulse lasts exactly one cycle
    property p_rel_one;
        @(posedge clk_in) disable iff (!rst_n_in)
        $fell(rel_n_q) |-> !rel_oe_n_q ##1 (rel_n_q && rel_oe_n_q);
    endproperty
    a_rel_one: assert property (p_rel_one) else $error("release not one cycle");

    // grant follows release by one cycle
    property p_grant;
        @(posedge clk_in) disable iff (!rst_n_in)
        !rel_n_q && !rel_oe_n_q |-> grant_n_q ##1 !grant_n_q;
    endproperty
    a_grant: assert property (p_grant) else $error("grant missing");

    // agent valid never driven while processor masters
    property p_valid;
        @(posedge clk_in) disable iff (!rst_n_in)
        val_oe_n_q |-> val_n_q;
    endproperty
    a_valid: assert property (p_valid) else $error("valid while released");

    // command parity odd whenever valid driven
    property p_cpar;
        @(posedge clk_in) disable iff (!rst_n_in)
        !val_n_q |-> ^{cmd_q, cpar_q};
    endproperty
    a_cpar: assert property (p_cpar) else $error("command parity even");

    // response parity and valid low the cycle after each request
    property p_resp;
        @(posedge clk_in) disable iff (!rst_n_in)
        send_resp |=> !rval_n_q && (^{resp_q, rpar_q});
    endproperty
    a_resp: assert property (p_resp) else $error("response bad");

    // ready deasserted one cycle after any cycle without capacity
    property p_rrdy;
        @(posedge clk_in) disable iff (!rst_n_in)
        !read_ok_in |=> rrdy_n_q;
    endproperty
    a_rrdy: assert property (p_rrdy) else $error("read ready without capacity");

    property p_wrdy;
        @(posedge clk_in) disable iff (!rst_n_in)
        !write_ok_in |=> wrdy_n_q;
    endproperty
    a_wrdy: assert property (p_wrdy) else $error("write ready without capacity");

    // globally performed only after user says so
    property p_gperf;
        @(posedge clk_in) disable iff (!rst_n_in)
        $fell(gperf_n_q) |-> $past(all_performed_in);
    endproperty
    a_gperf: assert property (p_gperf) else $error("performed too early");
endmodule : sbi_agent

// ==== bench/sbi_proc_model.sv ====
`timescale 1ns/100ps
// behavioural processor at the far side of the agent
module sbi_proc_model (
    input wire logic clk_in,                          // interface clock
    input wire logic rst_n_in,                        // async reset, active low
    input wire logic want_in,                         // has a request to issue
    input wire logic tx_go_in,                        // drive one word now
    input wire logic [sbi_pkg::CMD_W-1:0] tx_cmd_in,  // command word
    input wire logic [sbi_pkg::AD_W-1:0] tx_ad_in,    // address/data word
    input wire logic tx_bad_in,                       // flip command parity
    input wire logic st_go_in,                        // issue a state response
    input wire logic [sbi_pkg::STATE_W-1:0] st_in,    // state value
    input wire logic st_bad_in,                       // flip state parity
    input wire logic cor_in,                          // report corrected error
    input wire logic unc_in,                          // report tag error
    input wire logic grant_n_in,                      // grant from agent
    output logic req_n_out,                           // bus request
    output logic rel_n_out,                           // release value
    output logic [sbi_pkg::CMD_W-1:0] cmd_out,        // command value
    output logic cpar_out,                            // command parity
    output logic [sbi_pkg::AD_W-1:0] ad_out,          // address/data value
    output logic [sbi_pkg::ECC_W-1:0] ecc_out,        // check bits
    output logic val_n_out,                           // valid value
    output logic [sbi_pkg::STATE_W-1:0] st_out,       // state bus
    output logic spar_out,                            // state parity
    output logic stv_n_out,                           // state valid
    output logic cor_n_out,                           // corrected error
    output logic unc_n_out                            // tag error
);
    logic own, rel_q, gone_q, val_q, par_q;
    logic [sbi_pkg::CMD_W-1:0] cmd_q;
    logic [sbi_pkg::AD_W-1:0] ad_q;
    logic [sbi_pkg::ECC_W-1:0] ecc_q;
    // master from grant until own release
    assign own = !grant_n_in && !gone_q;
    // all pins change on the rising edge only
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            {rel_q, gone_q, par_q, val_q, req_n_out, stv_n_out} <= 6'h03;
            {cor_n_out, unc_n_out, spar_out} <= 3'h7;
            {cmd_q, ad_q, ecc_q, st_out} <= '0;
        end else begin
            req_n_out <= !(want_in && !own);
            rel_q <= own && !want_in && !rel_q;
            gone_q <= (gone_q || rel_q) && !grant_n_in;
            // word with odd parity (even when tx_bad_in) and valid
            val_q <= !(own && tx_go_in && !rel_q);
            if (own && tx_go_in) begin
                cmd_q <= tx_cmd_in;
                ad_q <= tx_ad_in;
                ecc_q <= tx_cmd_in[7:0];
                par_q <= ~^tx_cmd_in ^ tx_bad_in;
            end
            stv_n_out <= !st_go_in;
            st_out <= st_in;
            spar_out <= ~^st_in ^ st_bad_in;
            cor_n_out <= !cor_in;
            unc_n_out <= !unc_in;
        end
    end
    // released lines show the inverse of the last value, never a kind guess
    assign rel_n_out = own ? !rel_q : rel_q;
    assign cmd_out = own ? cmd_q : ~cmd_q;
    assign cpar_out = own ? par_q : ~par_q;
    assign ad_out = own ? ad_q : ~ad_q;
    assign ecc_out = own ? ecc_q : ~ecc_q;
    assign val_n_out = own ? val_q : ~val_q;
endmodule : sbi_proc_model

// ==== bench/system_bus_interface_test.sv ====
`timescale 1ns/100ps
module system_bus_interface_test;
    logic clk_in = 1'b0;
    logic rst_n_in, sys_reset_req_in, nmi_req_in, read_ok_in, write_ok_in, grant_en_in;
    logic all_performed_in, emu_mode_in, emu_cycle_in, cmd_req_in, resp_req_in;
    logic [11:0] cmd_in;
    logic [63:0] ad_in;
    logic [7:0] ecc_in;
    logic [4:0] resp_in;
    wire logic cmd_ack_out, resp_ack_out, rx_valid_out, rx_cmd_perr_out, state_valid_out;
    wire logic state_perr_out, cor_err_out, unc_err_out, proc_master_out, bus_grant_n_out;
    wire logic mastership_release_n_out, mastership_release_oe_n_out, read_accept_ready_n_out;
    wire logic write_accept_ready_n_out, command_bus_oe_n_out, command_parity_out;
    wire logic addr_data_bus_oe_n_out, bus_valid_n_out, bus_valid_oe_n_out;
    wire logic completion_response_parity_out, completion_response_valid_n_out;
    wire logic interface_reset_n_out, nonmaskable_irq_n_out, globally_performed_n_out;
    wire logic emulation_cycle_n_out, bus_request_n_in, mastership_release_n_in;
    wire logic command_parity_in, bus_valid_n_in, coherency_state_parity_in;
    wire logic coherency_state_valid_n_in, corrected_error_pulse_n_in;
    wire logic uncorrectable_error_pulse_n_in, p_rel, p_cpar, p_val;
    wire logic [11:0] rx_cmd_out, command_bus_out, command_bus_in, p_cmd;
    wire logic [63:0] rx_ad_out, addr_data_bus_out, addr_data_bus_in, p_ad;
    wire logic [7:0] rx_ecc_out, addr_data_ecc_out, addr_data_ecc_in, p_ecc;
    wire logic [2:0] state_out, coherency_state_bus_in;
    wire logic [4:0] completion_response_bus_out;
    wire logic [5:0] lv = {read_accept_ready_n_out, write_accept_ready_n_out,
        interface_reset_n_out, nonmaskable_irq_n_out, globally_performed_n_out,
        emulation_cycle_n_out};
    logic want, tx_go, tx_bad, st_go, st_bad, cor, unc;
    logic [11:0] tx_cmd;
    logic [63:0] tx_ad;
    logic [2:0] st;
    logic [15:0] rnd = 16'h0015;
    int num_errors = 0;
    int checks_done = 0;
    int i;
    logic [84:0] qc[$], qr[$];
    logic [5:0] qp[$];
    logic [3:0] qs[$];
    logic [1:0] qe[$];

    always #25 clk_in = ~clk_in;

    sbi_agent DUT (.*);

    sbi_proc_model PROC (.clk_in(clk_in), .rst_n_in(rst_n_in), .want_in(want),
        .tx_go_in(tx_go), .tx_cmd_in(tx_cmd), .tx_ad_in(tx_ad), .tx_bad_in(tx_bad),
        .st_go_in(st_go), .st_in(st), .st_bad_in(st_bad), .cor_in(cor), .unc_in(unc),
        .grant_n_in(bus_grant_n_out), .req_n_out(bus_request_n_in), .rel_n_out(p_rel),
        .cmd_out(p_cmd), .cpar_out(p_cpar), .ad_out(p_ad), .ecc_out(p_ecc), .val_n_out(p_val),
        .st_out(coherency_state_bus_in), .spar_out(coherency_state_parity_in),
        .stv_n_out(coherency_state_valid_n_in), .cor_n_out(corrected_error_pulse_n_in),
        .unc_n_out(uncorrectable_error_pulse_n_in));

    // shared wires: agent value while it drives, else the processor's
    assign command_bus_in = command_bus_oe_n_out ? p_cmd : command_bus_out;
    assign command_parity_in = command_bus_oe_n_out ? p_cpar : command_parity_out;
    assign addr_data_bus_in = addr_data_bus_oe_n_out ? p_ad : addr_data_bus_out;
    assign addr_data_ecc_in = addr_data_bus_oe_n_out ? p_ecc : addr_data_ecc_out;
    assign bus_valid_n_in = bus_valid_oe_n_out ? p_val : bus_valid_n_out;
    assign mastership_release_n_in = mastership_release_oe_n_out ? p_rel
        : mastership_release_n_out;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic cmp(input string n, input logic [95:0] e, input logic [95:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : cmp

    task automatic complete_run;
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    // bounded wait; a stuck arbitration ends the run
    task automatic wait_master(input logic v);
        for (i = 0; i < 20 && proc_master_out !== v; i++) @(negedge clk_in);
        if (i == 20) begin
            num_errors++;
            complete_run();
        end
    endtask : wait_master

    // agent commands and completion responses, back to back
    task automatic burst(input int n);
        repeat (n) begin
            rnd = lfsr(rnd);
            cmd_in = rnd[11:0];
            ad_in = {rnd, ~rnd, lfsr(rnd), rnd ^ 16'h00ff};
            ecc_in = rnd[15:8];
            resp_in = rnd[4:0];
            {cmd_req_in, resp_req_in} = 2'h3;
            qc.push_back({~^cmd_in, cmd_in, ad_in, ecc_in});
            qp.push_back({~^resp_in, resp_in});
            @(negedge clk_in);
        end
        {cmd_req_in, resp_req_in} = 2'h0;
    endtask : burst

    // oldest note against each result as it shows, settled mid-cycle
    always @(negedge clk_in) begin
        if (rst_n_in === 1'b1 && bus_valid_oe_n_out === 1'b0 && bus_valid_n_out === 1'b0)
            cmp("cmd pins", qc.size() ? {1'b1, qc.pop_front()} : 'x, {cmd_ack_out,
                command_parity_out, command_bus_out, addr_data_bus_out,
                addr_data_ecc_out});
        if (completion_response_valid_n_out === 1'b0)
            cmp("response", qp.size() ? {1'b1, qp.pop_front()} : 'x, {resp_ack_out,
                completion_response_parity_out, completion_response_bus_out});
        if (rx_valid_out === 1'b1)
            cmp("rx word", qr.size() ? qr.pop_front() : 'x, {rx_cmd_perr_out, rx_cmd_out,
                rx_ad_out, rx_ecc_out});
        if (state_valid_out === 1'b1)
            cmp("state", qs.size() ? qs.pop_front() : 'x, {state_perr_out, state_out});
        if (cor_err_out === 1'b1 || unc_err_out === 1'b1)
            cmp("errors", qe.size() ? qe.pop_front() : 'x, {cor_err_out, unc_err_out});
    end

    initial begin
        {sys_reset_req_in, nmi_req_in, read_ok_in, write_ok_in, grant_en_in} = 5'h0;
        {all_performed_in, emu_mode_in, emu_cycle_in, cmd_req_in, resp_req_in} = 5'h08;
        {want, tx_go, tx_bad, st_go, st_bad, cor, unc} = 7'h0;
        {cmd_in, ad_in, ecc_in, resp_in, tx_cmd, tx_ad, st} = '0;
        rst_n_in = 1'b0;
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        cmp("reset pins", 3'h5, {bus_grant_n_out, interface_reset_n_out, bus_valid_n_out});
        rst_n_in = 1'b1;
        // flow control and misc levels follow random settings one cycle later
        repeat (16) begin
            rnd = lfsr(rnd);
            {read_ok_in, write_ok_in, sys_reset_req_in, nmi_req_in, all_performed_in,
                emu_cycle_in} = rnd[5:0];
            @(negedge clk_in);
            cmp("levels", 6'(~rnd[5:0]), lv);
        end
        {read_ok_in, write_ok_in, sys_reset_req_in, grant_en_in, emu_mode_in} = 5'h1a;
        burst(6);
        // processor asks for the bus; agent releases and grants
        want = 1'b1;
        wait_master(1'b1);
        cmp("granted", 2'h1, {bus_grant_n_out, command_bus_oe_n_out});
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            {tx_go, st_go, tx_bad, st_bad} = {2'h3, rnd[0], rnd[1]};
            {cor, unc} = k[0] ? 2'h1 : 2'h2;
            tx_cmd = rnd[11:0];
            tx_ad = {4{rnd}};
            st = rnd[4:2];
            qr.push_back({rnd[0], rnd[11:0], {4{rnd}}, rnd[7:0]});
            qs.push_back({rnd[1], rnd[4:2]});
            qe.push_back(k[0] ? 2'h1 : 2'h2);
            @(negedge clk_in);
        end
        {tx_go, st_go, cor, unc, want} = 5'h0;
        wait_master(1'b0);
        @(negedge clk_in);
        cmp("regained", 2'h2, {bus_grant_n_out, command_bus_oe_n_out});
        burst(4);
        repeat (4) @(negedge clk_in);
        cmp("leftover", 0, qc.size() + qr.size() + qp.size() + qs.size() + qe.size());
        complete_run();
    end
endmodule : system_bus_interface_test
